// File: core/lrpc_pkg.sv
// Purpose: constants shared by the linear rail protection control block
// Assumes: 50 MHz clock, APB with 32-bit data
// Notes:   times are in microseconds; cycle counts derive from them
package lrpc_pkg;
  // ===========================================================
  // clock and timing
  localparam int CLK_MHZ            = 50;
  localparam int AR_LIMIT_OFF_US    = 200;
  localparam int AUX_LIMIT_OFF_US   = 200;
  localparam int AR_LIMIT_OFF_CYC   = AR_LIMIT_OFF_US * CLK_MHZ;
  localparam int AUX_LIMIT_OFF_CYC  = AUX_LIMIT_OFF_US * CLK_MHZ;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_RESTART = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_DIAG    = 8'h0c;
  // ===========================================================
  // config register fields
  localparam int CFG_TRK_BIT    = 0;
  localparam int CFG_ARLOW_BIT  = 1;
  localparam int CFG_XOVEN_BIT  = 2;
  localparam int CFG_MODE_LSB   = 4;
  localparam int CFG_LOCK_BIT   = 8;
  // restart register fields
  localparam int RST_AR_BIT     = 0;
  localparam int RST_AUX_BIT    = 1;
  localparam int RST_X_BIT      = 2;
  // diag flag positions
  localparam int DG_AR_OV  = 0;
  localparam int DG_AR_UV  = 1;
  localparam int DG_AUX_OV = 2;
  localparam int DG_AUX_UV = 3;
  localparam int DG_X_OV   = 4;
  localparam int DG_X_UV   = 5;
  localparam int DG_W      = 6;
  // ===========================================================
  // transceiver mode codes and mode reset value
  localparam logic [1:0] MODE_SLEEP_NOWAKE = 2'h0;
  localparam logic [1:0] MODE_LISTEN       = 2'h1;
  localparam logic [1:0] MODE_SLEEP_WAKE   = 2'h2;
  localparam logic [1:0] MODE_NORMAL       = 2'h3;
  localparam logic [1:0] MODE_RESET        = MODE_NORMAL;
  // analog reference limit level codes
  localparam logic [1:0] AR_LIM_INTERNAL = 2'h0;
  localparam logic [1:0] AR_LIM_EXTERNAL = 2'h1;
  localparam logic [1:0] AR_LIM_EXT_LOW  = 2'h2;
  localparam logic [1:0] AR_LIM_FOLDBACK = 2'h3;
endpackage

// File: core/lrpc_limit_timer.sv
// Purpose: times one continuous current-limit episode
// Assumes: limit_on already synchronised to clock
// Notes:   expire pulses once when the episode reaches LIMIT cycles
`timescale 1ns/1ps
module lrpc_limit_timer #(
  parameter int LIMIT = 10000
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic limit_on,
  output logic      expire
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
  localparam logic [CW-1:0] FULL = CW'(LIMIT);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_expire;

  // ===========================================================
  // counter
  always_comb begin
    next_count  = '0;
    next_expire = 1'b0;
    if (limit_on) begin
      // saturate so a long episode pulses expire only once
      next_count  = (count == FULL) ? count : count + CW'(1);
      next_expire = (count == LAST);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count  <= '0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      expire <= next_expire;
    end
  end
endmodule

// File: core/lrpc_ctrl.sv
// Purpose: protection control for analog-reference, auxiliary and
//          transceiver supply rails, reached over APB
// Assumes: comparator inputs are asynchronous; startup and init_main
//          come from the main state machine on the same clock
// Notes:   diag flags are write-one-to-clear, a new event wins
//
// What this block does
// - at start-up detect external pass transistor; if fitted, internal device off
// - default analog-reference limit level follows the start-up detection result
// - internal device in use: stay on under current limit, no timed shutdown
// - external transistor: limit lasting the off time switches rail off till restart
// - lower analog-reference limit selectable only when external transistor found
// - analog-reference output below foldback threshold selects foldback limit
// - auxiliary limit lasting its off time switches rail off till restart
// - auxiliary output low selects foldback limit level
// - analog-reference overvoltage turns rail off; either event flags and reports
// - auxiliary overvoltage turns rail off; either event flags and reports
// - auxiliary tracking chosen only during init, then locked
// - after reset transceiver rail and undervoltage on, overvoltage detector off
// - transceiver overvoltage detector enable accepted only in init state
// - enabled transceiver overvoltage turns rail off, flags and reports
// - transceiver undervoltage detector disabled while that rail is off
// - transceiver supply events never touch reset or fail-safe outputs
// - transceiver mode: 00 sleep, 01 listen, 10 sleep with wake, 11 normal
`timescale 1ns/1ps
module lrpc_ctrl
  import lrpc_pkg::*;
#(
  parameter int AR_OFF_CYCLES  = AR_LIMIT_OFF_CYC,
  parameter int AUX_OFF_CYCLES = AUX_LIMIT_OFF_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        startup,
  input  wire logic        init_main,
  input  wire logic        ar_ext_detect,
  input  wire logic        ar_limit,
  input  wire logic        ar_fold,
  input  wire logic        ar_ov,
  input  wire logic        ar_uv,
  input  wire logic        aux_limit,
  input  wire logic        aux_fold,
  input  wire logic        aux_ov,
  input  wire logic        aux_uv,
  input  wire logic        xcvr_ov,
  input  wire logic        xcvr_uv,
  output logic             ar_rail_en,
  output logic             ar_internal_en,
  output logic             ar_external_en,
  output logic      [1:0]  ar_limit_level,
  output logic             aux_rail_en,
  output logic             aux_limit_foldback,
  output logic             aux_tracking_enable,
  output logic             transceiver_supply_rail,
  output logic             xcvr_ov_det_en,
  output logic             xcvr_uv_det_en,
  output logic      [1:0]  xcvr_mode,
  output logic             diag_event,
  output logic             failsafe_req
);
  // ===========================================================
  // comparator synchronisers
  localparam int NS = 11;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic s_ext, s_arl, s_arf, s_arov, s_aruv;
  logic s_axl, s_axf, s_axov, s_axuv, s_xov, s_xuv;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {ar_ext_detect, ar_limit, ar_fold, ar_ov, ar_uv,
                aux_limit, aux_fold, aux_ov, aux_uv, xcvr_ov, xcvr_uv};
      sync2 <= sync1;
    end
  end
  assign {s_ext, s_arl, s_arf, s_arov, s_aruv,
          s_axl, s_axf, s_axov, s_axuv, s_xov, s_xuv} = sync2;

  // ===========================================================
  // limit duration timers
  logic          ext_pnp,  next_ext_pnp;
  logic          ar_off,   next_ar_off;
  logic          aux_off,  next_aux_off;
  logic ar_expire;
  logic aux_expire;

  lrpc_limit_timer #(.LIMIT(AR_OFF_CYCLES)) u_ar_timer (
    .clock    (clock),
    .rst_b    (rst_b),
    .limit_on (s_arl & ext_pnp & ~ar_off),
    .expire   (ar_expire)
  );

  lrpc_limit_timer #(.LIMIT(AUX_OFF_CYCLES)) u_aux_timer (
    .clock    (clock),
    .rst_b    (rst_b),
    .limit_on (s_axl & ~aux_off),
    .expire   (aux_expire)
  );

  // ===========================================================
  // state registers
  logic          x_off,    next_x_off;
  logic          init_q,   next_init_q;
  logic          trk_window;
  logic          trk,      next_trk;
  logic          ar_low,   next_ar_low;
  logic          xov_en,   next_xov_en;
  logic          locked,   next_locked;
  logic [1:0]    mode,     next_mode;
  logic [DG_W-1:0] diag,   next_diag;
  logic [DG_W-1:0] dg_set;
  logic [31:0]   next_prdata;
  logic          wr;
  logic          rd_setup;
  logic          mapped;

  assign mapped   = (paddr == OFS_CFG) || (paddr == OFS_RESTART) ||
                    (paddr == OFS_STATUS) || (paddr == OFS_DIAG);
  assign wr       = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = penable;
  assign pslverr  = psel & penable & ~mapped;
  assign trk_window = init_main & ~locked;

  always_comb begin
    dg_set            = '0;
    dg_set[DG_AR_OV]  = s_arov;
    dg_set[DG_AR_UV]  = s_aruv;
    dg_set[DG_AUX_OV] = s_axov;
    dg_set[DG_AUX_UV] = s_axuv;
    dg_set[DG_X_OV]   = s_xov & xov_en;
    dg_set[DG_X_UV]   = s_xuv & ~x_off;
  end

  always_comb begin
    next_ext_pnp = ext_pnp;
    next_ar_off  = ar_off;
    next_aux_off = aux_off;
    next_x_off   = x_off;
    next_trk     = trk;
    next_ar_low  = ar_low;
    next_xov_en  = xov_en;
    next_mode    = mode;
    next_init_q  = init_main;
    // lock once the init state has been left
    next_locked  = locked | (init_q & ~init_main);
    next_diag    = diag;
    next_prdata  = prdata;
    // detection result tracks the pin only while starting up
    if (startup) begin
      next_ext_pnp = s_ext;
    end
    if (wr && paddr == OFS_CFG) begin
      next_ar_low = pwdata[CFG_ARLOW_BIT] & ext_pnp;
      next_mode   = pwdata[CFG_MODE_LSB +: 2];
      if (trk_window) begin
        next_trk = pwdata[CFG_TRK_BIT];
      end
      if (init_main) begin
        next_xov_en = pwdata[CFG_XOVEN_BIT];
      end
    end
    // restart clears the latch; a new off event in the same cycle wins
    if (wr && paddr == OFS_RESTART) begin
      if (pwdata[RST_AR_BIT]) next_ar_off = 1'b0;
      if (pwdata[RST_AUX_BIT]) next_aux_off = 1'b0;
      if (pwdata[RST_X_BIT]) next_x_off = 1'b0;
    end
    if (wr && paddr == OFS_DIAG) begin
      next_diag = diag & ~pwdata[DG_W-1:0];
    end
    next_diag = next_diag | dg_set;
    if ((ar_expire && ext_pnp) || s_arov) begin
      next_ar_off = 1'b1;
    end
    if (aux_expire || s_axov) begin
      next_aux_off = 1'b1;
    end
    if (s_xov && xov_en) begin
      next_x_off = 1'b1;
    end
    if (rd_setup) begin
      unique case (paddr)
        OFS_CFG: next_prdata = {23'h0, locked, 2'h0, mode, 1'b0,
                                xov_en, ar_low, trk};
        OFS_STATUS: next_prdata = {24'h0, ext_pnp, x_off, aux_off, ar_off,
                                   1'b0, ~x_off, ~aux_off, ~ar_off};
        OFS_DIAG: next_prdata = {26'h0, diag};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_pnp <= 1'b0;
      ar_off  <= 1'b0;
      aux_off <= 1'b0;
      x_off   <= 1'b0;
      trk     <= 1'b0;
      ar_low  <= 1'b0;
      xov_en  <= 1'b0;
      locked  <= 1'b0;
      init_q  <= 1'b0;
      mode    <= MODE_RESET;
      diag    <= '0;
      prdata  <= 32'h0;
    end else begin
      ext_pnp <= next_ext_pnp;
      ar_off  <= next_ar_off;
      aux_off <= next_aux_off;
      x_off   <= next_x_off;
      trk     <= next_trk;
      ar_low  <= next_ar_low;
      xov_en  <= next_xov_en;
      locked  <= next_locked;
      init_q  <= next_init_q;
      mode    <= next_mode;
      diag    <= next_diag;
      prdata  <= next_prdata;
    end
  end

  // ===========================================================
  // rail outputs
  logic [1:0] next_ar_lvl;
  logic       next_evt;
  logic       next_fs;

  always_comb begin
    if (s_arf) begin
      next_ar_lvl = AR_LIM_FOLDBACK;
    end else if (!ext_pnp) begin
      next_ar_lvl = AR_LIM_INTERNAL;
    end else if (ar_low) begin
      next_ar_lvl = AR_LIM_EXT_LOW;
    end else begin
      next_ar_lvl = AR_LIM_EXTERNAL;
    end
    next_evt = |(dg_set & ~diag);
    // only the safety rails feed fail-safe
    next_fs  = s_arov | s_aruv | s_axov | s_axuv;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ar_limit_level     <= AR_LIM_INTERNAL;
      aux_limit_foldback <= 1'b0;
      diag_event         <= 1'b0;
      failsafe_req       <= 1'b0;
    end else begin
      ar_limit_level     <= next_ar_lvl;
      aux_limit_foldback <= s_axf;
      diag_event         <= next_evt;
      failsafe_req       <= next_fs;
    end
  end

  assign ar_rail_en              = ~ar_off;
  assign ar_internal_en          = ~ar_off & ~ext_pnp;
  assign ar_external_en          = ~ar_off & ext_pnp;
  assign aux_rail_en             = ~aux_off;
  assign aux_tracking_enable     = trk;
  assign transceiver_supply_rail = ~x_off;
  assign xcvr_ov_det_en          = xov_en;
  assign xcvr_uv_det_en          = ~x_off;
  assign xcvr_mode               = mode;

  // ===========================================================
  // assertions
  sequence ar_lim_held;
    s_arl & ext_pnp & ~ar_off & ~startup;
  endsequence

  a_ar_int_no_off: assert property (@(posedge clock) disable iff (!rst_b)
    (!ext_pnp && !s_arov && !$past(ext_pnp) && !ar_off) |=> !ar_off)
    else $error("analog rail turned off without cause");

  a_ar_timed_off: assert property (@(posedge clock) disable iff (!rst_b)
    ar_expire && ext_pnp |=> ar_off)
    else $error("analog rail not off after limit time");

  a_aux_timed_off: assert property (@(posedge clock) disable iff (!rst_b)
    aux_expire |=> aux_off)
    else $error("aux rail not off after limit time");

  a_ar_ov_off: assert property (@(posedge clock) disable iff (!rst_b)
    s_arov |=> ar_off && diag[DG_AR_OV])
    else $error("analog overvoltage not handled");

  a_aux_ov_off: assert property (@(posedge clock) disable iff (!rst_b)
    s_axov |=> aux_off && diag[DG_AUX_OV])
    else $error("aux overvoltage not handled");

  a_trk_locked: assert property (@(posedge clock) disable iff (!rst_b)
    locked |=> $stable(trk))
    else $error("tracking changed after lock");

  a_xov_init_only: assert property (@(posedge clock) disable iff (!rst_b)
    !$past(init_main) |-> $stable(xov_en))
    else $error("overvoltage enable changed outside init");

  a_x_ov_off: assert property (@(posedge clock) disable iff (!rst_b)
    s_xov && xov_en |=> x_off && diag[DG_X_OV])
    else $error("transceiver overvoltage not handled");

  a_x_uv_masked: assert property (@(posedge clock) disable iff (!rst_b)
    x_off |=> !$rose(diag[DG_X_UV]))
    else $error("undervoltage detector on with rail off");

  a_x_no_fs: assert property (@(posedge clock) disable iff (!rst_b)
    !s_arov && !s_aruv && !s_axov && !s_axuv |=> !failsafe_req)
    else $error("transceiver event reached fail-safe");

  a_restart_clr: assert property (@(posedge clock) disable iff (!rst_b)
    wr && paddr == OFS_RESTART && pwdata[RST_AUX_BIT] && !aux_expire && !s_axov
    |=> !aux_off)
    else $error("restart did not clear aux latch");

  a_ar_low_ext: assert property (@(posedge clock) disable iff (!rst_b)
    ar_limit_level == AR_LIM_EXT_LOW |-> $past(ext_pnp))
    else $error("low limit without external transistor");

  a_fold_lvl: assert property (@(posedge clock) disable iff (!rst_b)
    s_arf |=> ar_limit_level == AR_LIM_FOLDBACK)
    else $error("foldback level not applied");

  a_lim_timing: assert property (@(posedge clock) disable iff (!rst_b)
    ar_lim_held [*2] |-> !ar_expire || !$past(ar_expire))
    else $error("expire pulse longer than one cycle");
endmodule

// File: dv/lrpc_host_model.sv
// Purpose: host side model, an APB master issuing config and restart writes
// Assumes: slave answers with pready; the master assumes no wait count
// Notes:   hang rises when a transfer never sees pready
`timescale 1ns/1ps
module lrpc_host_model
  import lrpc_pkg::*;
(
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang = 1'b0;
  end
  // =============================================================
  // one transfer: setup, then access until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hang    <= (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
  // unused transceiver feeding an external load is parked asleep
  task automatic park_xcvr();
    logic [31:0] r;
    logic        e;
    xfer(1'b1, OFS_CFG, {26'h0, MODE_SLEEP_NOWAKE, 4'h0}, r, e);
  endtask
endmodule

// File: dv/linear_regulator_protection_ctrl_tb.sv
// Purpose: self-checking bench for the linear rail protection control
// Assumes: limit timers shortened to OFF cycles
// Notes:   each scenario resets the block and judges its own results
`timescale 1ns/1ps
module linear_regulator_protection_ctrl_tb
  import lrpc_pkg::*;
;
  localparam int OFF = 8;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, hang, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        startup, init_main, ar_ext_detect, ar_limit, ar_fold, aux_limit, aux_fold, xcvr_ov, xcvr_uv;
  logic [3:0]  ev;
  logic        ar_rail_en, ar_internal_en, ar_external_en, aux_rail_en, aux_limit_foldback;
  logic        aux_tracking_enable, transceiver_supply_rail, xcvr_ov_det_en, xcvr_uv_det_en;
  logic        diag_event, failsafe_req;
  logic [1:0]  ar_limit_level, xcvr_mode;
  int          error_cnt = 0;
  int          samples_checked = 0;

  lrpc_ctrl #(.AR_OFF_CYCLES(OFF), .AUX_OFF_CYCLES(OFF)) lrpc_ctrl_i (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .startup(startup),
    .init_main(init_main), .ar_ext_detect(ar_ext_detect), .ar_limit(ar_limit), .ar_fold(ar_fold),
    .ar_ov(ev[0]), .ar_uv(ev[1]), .aux_limit(aux_limit), .aux_fold(aux_fold), .aux_ov(ev[2]),
    .aux_uv(ev[3]), .xcvr_ov(xcvr_ov), .xcvr_uv(xcvr_uv), .ar_rail_en(ar_rail_en),
    .ar_internal_en(ar_internal_en), .ar_external_en(ar_external_en), .ar_limit_level(ar_limit_level),
    .aux_rail_en(aux_rail_en), .aux_limit_foldback(aux_limit_foldback),
    .aux_tracking_enable(aux_tracking_enable), .transceiver_supply_rail(transceiver_supply_rail),
    .xcvr_ov_det_en(xcvr_ov_det_en), .xcvr_uv_det_en(xcvr_uv_det_en), .xcvr_mode(xcvr_mode),
    .diag_event(diag_event), .failsafe_req(failsafe_req));
  lrpc_host_model lrpc_host_model_i (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // =============================================================
  // checking and control helpers
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  always @(posedge clock) begin
    if (hang === 1'b1) begin
      chk1(hang, 1'b0);
      summarize();
    end
  end
  function automatic logic pick(input int w);
    case (w)
      0: pick = ar_rail_en;
      1: pick = aux_rail_en;
      2: pick = transceiver_supply_rail;
      default: pick = diag_event;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic v, output int n);
    n = 0;
    while (pick(w) !== v && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (n >= 40) begin
      chk1(pick(w), v);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    lrpc_host_model_i.xfer(1'b1, a, d, rdat, err);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    lrpc_host_model_i.xfer(1'b0, a, 32'h0, rdat, err);
    chk(rdat, e);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    {startup, init_main, ar_ext_detect, ar_limit, ar_fold, aux_limit, aux_fold} <= 7'h0;
    {ev, xcvr_ov, xcvr_uv} <= 6'h0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
  endtask
  task automatic boot(input logic ext);
    ar_ext_detect <= ext;
    startup <= 1'b1;
    repeat (6) @(posedge clock);
    startup <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // =============================================================
  // scenarios
  task automatic t_internal();
    do_reset();
    chk1(transceiver_supply_rail, 1'b1);
    chk1(xcvr_ov_det_en, 1'b0);
    chk1(xcvr_uv_det_en, 1'b1);
    chk({30'h0, xcvr_mode}, {30'h0, MODE_RESET});
    boot(1'b0);
    chk1(ar_internal_en, 1'b1);
    chk({30'h0, ar_limit_level}, {30'h0, AR_LIM_INTERNAL});
    wr(OFS_CFG, 32'h32);
    rd(OFS_CFG, 32'h30);
    ar_limit <= 1'b1;
    repeat (3 * OFF) @(posedge clock);
    chk1(ar_rail_en, 1'b1);
    ar_fold <= 1'b1;
    repeat (4) @(posedge clock);
    chk({30'h0, ar_limit_level}, {30'h0, AR_LIM_FOLDBACK});
  endtask
  task automatic t_external();
    int n;
    do_reset();
    boot(1'b1);
    chk1(ar_external_en, 1'b1);
    chk1(ar_internal_en, 1'b0);
    chk({30'h0, ar_limit_level}, {30'h0, AR_LIM_EXTERNAL});
    rd(OFS_STATUS, 32'h87);
    wr(OFS_CFG, 32'h32);
    repeat (2) @(posedge clock);
    chk({30'h0, ar_limit_level}, {30'h0, AR_LIM_EXT_LOW});
    ar_limit <= 1'b1;
    wait_for(0, 1'b0, n);
    chk1(n >= OFF && n <= OFF + 6, 1'b1);
    ar_limit <= 1'b0;
    repeat (6) @(posedge clock);
    chk1(ar_rail_en, 1'b0);
    wr(OFS_RESTART, 32'h1 << RST_AR_BIT);
    wait_for(0, 1'b1, n);
    chk1(n <= 2, 1'b1);
  endtask
  task automatic t_aux();
    int n;
    do_reset();
    aux_fold <= 1'b1;
    repeat (4) @(posedge clock);
    chk1(aux_limit_foldback, 1'b1);
    aux_limit <= 1'b1;
    wait_for(1, 1'b0, n);
    chk1(n >= OFF && n <= OFF + 6, 1'b1);
    aux_limit <= 1'b0;
    repeat (6) @(posedge clock);
    chk1(aux_rail_en, 1'b0);
    wr(OFS_RESTART, 32'h1 << RST_AUX_BIT);
    wait_for(1, 1'b1, n);
    chk1(n <= 2, 1'b1);
  endtask
  task automatic t_ovuv();
    int n;
    for (int i = 0; i < 4; i++) begin
      do_reset();
      ev <= 4'h1 << i;
      wait_for(3, 1'b1, n);
      repeat (2) @(posedge clock);
      chk1(failsafe_req, 1'b1);
      rd(OFS_DIAG, 32'h1 << i);
      ev <= 4'h0;
      repeat (5) @(posedge clock);
      chk1(ar_rail_en, i != 0);
      chk1(aux_rail_en, i != 2);
      wr(OFS_DIAG, 32'h1 << i);
      wr(OFS_RESTART, 32'h3);
      @(posedge clock);
      chk({30'h0, ar_rail_en, aux_rail_en}, 32'h3);
      rd(OFS_DIAG, 32'h0);
    end
  endtask
  task automatic t_xcvr();
    int n;
    do_reset();
    wr(OFS_CFG, 32'h34);
    @(posedge clock);
    chk1(xcvr_ov_det_en, 1'b0);
    init_main <= 1'b1;
    wr(OFS_CFG, 32'h34);
    @(posedge clock);
    chk1(xcvr_ov_det_en, 1'b1);
    xcvr_ov <= 1'b1;
    wait_for(3, 1'b1, n);
    repeat (2) @(posedge clock);
    chk1(transceiver_supply_rail, 1'b0);
    chk1(xcvr_uv_det_en, 1'b0);
    xcvr_ov <= 1'b0;
    xcvr_uv <= 1'b1;
    repeat (6) @(posedge clock);
    rd(OFS_DIAG, 32'h1 << DG_X_OV);
    chk1(failsafe_req, 1'b0);
    wr(OFS_RESTART, 32'h1 << RST_X_BIT);
    repeat (6) @(posedge clock);
    chk1(transceiver_supply_rail, 1'b1);
    rd(OFS_DIAG, 32'h30);
    chk1(failsafe_req, 1'b0);
  endtask
  task automatic t_track();
    do_reset();
    init_main <= 1'b1;
    wr(OFS_CFG, 32'h31);
    @(posedge clock);
    chk1(aux_tracking_enable, 1'b1);
    init_main <= 1'b0;
    repeat (3) @(posedge clock);
    wr(OFS_CFG, 32'h30);
    rd(OFS_CFG, 32'h131);
    for (int m = 3; m >= 1; m--) begin
      wr(OFS_CFG, 32'(m) << CFG_MODE_LSB);
      @(posedge clock);
      chk({30'h0, xcvr_mode}, 32'(m));
    end
    lrpc_host_model_i.park_xcvr();
    @(posedge clock);
    chk({30'h0, xcvr_mode}, {30'h0, MODE_SLEEP_NOWAKE});
    lrpc_host_model_i.xfer(1'b1, 8'h10, 32'hffff_ffff, rdat, err);
    chk1(err, 1'b1);
    lrpc_host_model_i.xfer(1'b0, 8'h10, 32'h0, rdat, err);
    chk({err, rdat[30:0]}, 32'h8000_0000);
    rd(OFS_RESTART, 32'h0);
  endtask
  initial begin
    t_internal();
    t_external();
    t_aux();
    t_ovuv();
    t_xcvr();
    t_track();
    summarize();
  end
endmodule
